// ==== bench/scif_host.sv ====
/*
 * Host side sink for the response stream: accepts bytes, records them.
 * Assumes the bench drives clr_i and stall_i off the falling edge.
 */
module scif_host (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic last_i,
  input wire logic [7:0] data_i,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  logic [7:0] mem [0:2047];
  int cnt = 0;
  int lastpos = -1;
  //////////////////////////////////////////////////////////////////////
  // Ready pattern, two of four cycles held off while stalling
  always @(negedge clk_i) begin
    ph <= ph + 2'h1;
    ready_o <= !stall_i || ph[1];
  end
  // Capture of each accepted byte and of the flagged final position
  always @(posedge clk_i) begin
    if (clr_i) begin
      cnt <= 0;
      lastpos <= -1;
    end else if (valid_i && ready_o) begin
      mem[cnt] <= data_i;
      cnt <= cnt + 1;
      if (last_i) lastpos <= cnt;
    end
  end
endmodule

// ==== bench/scif_top_sva.sv ====
/*
 * Checker for the formatter: request answer, stream and credentials.
 * Assumes it is bound onto scif_top and sees only its ports.
 */
module scif_top_sva (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic REQ_VALID_I,
  input wire logic [7:0] REQ_PROTOCOL_I,
  input wire logic [15:0] REQ_SPECIFIC_I,
  input wire logic [31:0] REQ_ALLOC_LEN_I,
  input wire logic REQ_READY_O,
  input wire logic REQ_REJECT_O,
  input wire logic REQ_DONE_O,
  input wire logic DATA_VALID_O,
  input wire logic [7:0] DATA_O,
  input wire logic DATA_LAST_O,
  input wire logic DATA_READY_I,
  input wire logic CRED_WR_I,
  input wire logic [1:0] CRED_SEL_I,
  input wire logic [31:0] CRED_DATA_I,
  input wire logic [31:0] FACTORY_CRED_O,
  input wire logic [31:0] OWNER_CRED_O,
  input wire logic [31:0] RANGE_ADMIN_CRED_O,
  input wire logic [31:0] ERASE_ADMIN_CRED_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  // Request taken and whether its codes select this page
  wire take = REQ_VALID_I && REQ_READY_O;
  wire good = REQ_PROTOCOL_I == scif_pkg::PROTO_INFO &&
    REQ_SPECIFIC_I == scif_pkg::SPEC_COMPLIANCE;
  sequence s_take_data;
    take && good && REQ_ALLOC_LEN_I != 32'h0;
  endsequence
  // Done comes with the stream already quiet, and nothing follows at once
  sequence s_tail;
    (!DATA_VALID_O && REQ_DONE_O) ##1 !DATA_VALID_O;
  endsequence
  //////////////////////////////////////////////////////////////////////
  a_bad_reject: assert property (
    take && !good |=> REQ_REJECT_O && !DATA_VALID_O)
    else $error("mismatched codes not refused");
  a_busy_first: assert property (
    s_take_data |=> !REQ_READY_O ##1 DATA_VALID_O)
    else $error("first byte late");
  a_zero_done: assert property (
    take && good && REQ_ALLOC_LEN_I == 32'h0 |=> REQ_DONE_O)
    else $error("empty transfer not finished");
  a_byte_holds: assert property (
    DATA_VALID_O && !DATA_READY_I |=>
    DATA_VALID_O && $stable(DATA_O) && $stable(DATA_LAST_O))
    else $error("byte changed before acceptance");
  a_last_done: assert property (
    DATA_VALID_O && DATA_READY_I && DATA_LAST_O |=> s_tail)
    else $error("stream did not stop after last byte");
  a_idle_quiet: assert property (
    REQ_READY_O |-> !DATA_VALID_O)
    else $error("byte offered while idle");
  a_owner_write: assert property (
    CRED_WR_I && CRED_SEL_I == scif_pkg::CRED_OWNER |=>
    OWNER_CRED_O == $past(CRED_DATA_I))
    else $error("owner credential not written");
  a_sel_refused: assert property (
    CRED_WR_I && CRED_SEL_I == 2'h3 |=>
    $stable(OWNER_CRED_O) && $stable(RANGE_ADMIN_CRED_O) &&
    $stable(ERASE_ADMIN_CRED_O))
    else $error("unused select changed a credential");
  a_factory_fixed: assert property (
    !CRED_WR_I |=> $stable(OWNER_CRED_O) && $stable(RANGE_ADMIN_CRED_O) &&
    $stable(ERASE_ADMIN_CRED_O) && FACTORY_CRED_O == scif_pkg::FACTORY_CRED)
    else $error("credential changed without a write");
endmodule

bind scif_top scif_top_sva i_scif_top_sva (.MCLK_I(MCLK_I),
  .RST_N_I(RST_N_I), .REQ_VALID_I(REQ_VALID_I),
  .REQ_PROTOCOL_I(REQ_PROTOCOL_I), .REQ_SPECIFIC_I(REQ_SPECIFIC_I),
  .REQ_ALLOC_LEN_I(REQ_ALLOC_LEN_I), .REQ_READY_O(REQ_READY_O),
  .REQ_REJECT_O(REQ_REJECT_O), .REQ_DONE_O(REQ_DONE_O),
  .DATA_VALID_O(DATA_VALID_O), .DATA_O(DATA_O),
  .DATA_LAST_O(DATA_LAST_O), .DATA_READY_I(DATA_READY_I),
  .CRED_WR_I(CRED_WR_I), .CRED_SEL_I(CRED_SEL_I),
  .CRED_DATA_I(CRED_DATA_I), .FACTORY_CRED_O(FACTORY_CRED_O),
  .OWNER_CRED_O(OWNER_CRED_O), .RANGE_ADMIN_CRED_O(RANGE_ADMIN_CRED_O),
  .ERASE_ADMIN_CRED_O(ERASE_ADMIN_CRED_O));

// ==== bench/security_compliance_info_formatter_test.sv ====
/*
 * Self-checking bench for the formatter: requests, streams, credentials.
 * Assumes scif_top, scif_host and the bound checker are compiled first.
 */
module security_compliance_info_formatter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, req_valid, std_sel, cred_wr, stall, clr, rej;
  logic ready, reject, done, dvalid, dlast, dready;
  logic [7:0] proto, level, dout;
  logic [15:0] spec;
  logic [31:0] alloc, cred_data, fcred, ocred, rcred, ecred;
  logic [1:0] dcnt, cred_sel;
  int error_cnt = 0;
  int tests_run = 0;
  scif_top i_scif_top (.MCLK_I(clk), .RST_N_I(rst_n),
    .REQ_VALID_I(req_valid), .REQ_PROTOCOL_I(proto),
    .REQ_SPECIFIC_I(spec), .REQ_ALLOC_LEN_I(alloc),
    .REQ_DESC_COUNT_I(dcnt), .REQ_STD_SEL_I(std_sel),
    .REQ_LEVEL_I(level), .REQ_READY_O(ready), .REQ_REJECT_O(reject),
    .REQ_DONE_O(done), .DATA_VALID_O(dvalid), .DATA_O(dout),
    .DATA_LAST_O(dlast), .DATA_READY_I(dready), .CRED_WR_I(cred_wr),
    .CRED_SEL_I(cred_sel), .CRED_DATA_I(cred_data),
    .FACTORY_CRED_O(fcred), .OWNER_CRED_O(ocred),
    .RANGE_ADMIN_CRED_O(rcred), .ERASE_ADMIN_CRED_O(ecred));
  scif_host i_scif_host (.clk_i(clk), .clr_i(clr), .stall_i(stall),
    .valid_i(dvalid), .last_i(dlast), .data_i(dout), .ready_o(dready));
  //////////////////////////////////////////////////////////////////////
  // Comparison, verdict and expected response bytes
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize();
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function logic [7:0] fld(logic [127:0] s, logic [9:0] n, int p);
    return (p < n) ? s[8*(int'(n)-1-p) +: 8] : 8'h00;
  endfunction
  function logic [7:0] exp_byte(int i, int k, logic sl, logic [7:0] lv);
    int o;
    logic [31:0] len;
    len = scif_pkg::DESC_BYTES * k;
    if (i < 4) return len[8*(3-i) +: 8];
    o = i - 4;
    if (o >= len) return 8'h00;
    o = o % 528;
    if (o < 2) return scif_pkg::DESC_TYPE_CRYPTO[8*(1-o) +: 8];
    if (o < 4) return 8'h00;
    if (o < 8) return scif_pkg::DESC_LEN_CRYPTO[8*(7-o) +: 8];
    if (o == 8) return sl ? scif_pkg::STD_140_3 : scif_pkg::STD_140_2;
    if (o == 9) return lv;
    if (o < 16) return 8'h00;
    if (o < 144) return fld(scif_pkg::HW_STR, scif_pkg::HW_STR_LEN, o-16);
    if (o < 272) return fld(scif_pkg::VER_STR, scif_pkg::VER_STR_LEN, o-144);
    return fld(scif_pkg::NAME_STR, scif_pkg::NAME_STR_LEN, o-272);
  endfunction
  //////////////////////////////////////////////////////////////////////
  // One request, held for one edge, then a bounded wait for its end
  task req(input logic [7:0] p, input logic [15:0] s, input logic [31:0] a,
    input logic [1:0] k, input logic sl, input logic [7:0] lv,
    input logic st);
    int w;
    @(negedge clk);
    clr = 1'b1;
    stall = st;
    @(negedge clk);
    clr = 1'b0;
    {proto, spec, alloc, dcnt, std_sel, level} = {p, s, a, k, sl, lv};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    w = 0;
    while (done !== 1'b1 && reject !== 1'b1 && w < 5000) begin
      @(negedge clk);
      w++;
    end
    rej = reject;
    if (w == 5000) error_cnt++;
  endtask
  // Received bytes against the layout, count and final flag
  task cmp(input int n, input int k, input logic sl, input logic [7:0] lv);
    chk(i_scif_host.cnt, n);
    chk(i_scif_host.lastpos, n - 1);
    for (int i = 0; i < n; i++) begin
      chk(i_scif_host.mem[i], exp_byte(i, k, sl, lv));
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_full();
    req(8'h00, 16'h0002, 32'h0000_042A, 2'h2, 1'b0, 8'h32, 1'b1);
    cmp(1066, 2, 1'b0, 8'h32);
  endtask
  task t_trunc();
    req(8'h00, 16'h0002, 32'h0000_0300, 2'h3, 1'b1, 8'h33, 1'b0);
    cmp(768, 3, 1'b1, 8'h33);
    req(8'h00, 16'h0002, 32'h0000_0216, 2'h0, 1'b1, 8'h31, 1'b0);
    cmp(534, 1, 1'b1, 8'h31);
  endtask
  task t_reject();
    req(8'h01, 16'h0002, 32'h0000_0010, 2'h1, 1'b0, 8'h32, 1'b0);
    chk(rej, 1'b1);
    req(8'h00, 16'h0001, 32'h0000_0010, 2'h1, 1'b0, 8'h32, 1'b0);
    chk(rej, 1'b1);
    chk(i_scif_host.cnt, 0);
    req(8'h00, 16'h0002, 32'h0000_0000, 2'h1, 1'b0, 8'h32, 1'b0);
    chk(rej, 1'b0);
    chk(i_scif_host.cnt, 0);
  endtask
  task t_cred();
    chk(fcred, scif_pkg::FACTORY_CRED);
    chk(ocred, scif_pkg::FACTORY_CRED);
    chk(rcred, scif_pkg::FACTORY_CRED);
    chk(ecred, scif_pkg::FACTORY_CRED);
    // Back to back replacement of all three, then an unused select
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      cred_wr = 1'b1;
      cred_sel = 2'(i);
      cred_data = 32'h5A5A_0000 + i;
    end
    @(negedge clk);
    cred_wr = 1'b0;
    chk(ocred, 32'h5A5A_0000);
    chk(rcred, 32'h5A5A_0001);
    chk(ecred, 32'h5A5A_0002);
    // Reset in mid-run brings every credential back to the factory value
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk(ocred, scif_pkg::FACTORY_CRED);
    chk(rcred, scif_pkg::FACTORY_CRED);
    chk(ecred, scif_pkg::FACTORY_CRED);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Clock, reset, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, req_valid, std_sel, cred_wr, stall, clr, rej} = 7'h02;
    {proto, level, spec, alloc, dcnt} = 66'h0;
    {cred_sel, cred_data} = 34'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_cred();
    t_full();
    t_trunc();
    t_reject();
    summarize();
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule

// ==== src/scif_desc.sv ====
/*
 * Byte source for one cryptographic-module compliance descriptor.
 * Assumes offset stays within 0 to 527; data is purely combinational.
 */
module scif_desc (
  scif_desc_if.src dsc
);

  //////////////////////////////////////////////////////////////////////////
  // Null terminated, null padded string byte
  function automatic logic [7:0] str_byte(input logic [127:0] s,
                                          input logic [9:0] len,
                                          input logic [9:0] idx);
    logic [9:0] sh;
    sh = len - idx - 10'h001;
    if (idx < len) begin
      return s[{sh[3:0], 3'h0} +: 8];
    end
    return 8'h00;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Field select by offset within the descriptor
  always_comb begin
    logic [9:0] o;
    o = dsc.offset;
    dsc.data = 8'h00;
    if (o < scif_pkg::OFS_LEN) begin
      if (o == 10'h001) begin
        dsc.data = scif_pkg::DESC_TYPE_CRYPTO[7:0];
      end else if (o == scif_pkg::OFS_TYPE) begin
        dsc.data = scif_pkg::DESC_TYPE_CRYPTO[15:8];
      end
    end else if (o < scif_pkg::OFS_STD) begin
      // Length counts the bytes after the length field
      dsc.data =
        scif_pkg::DESC_LEN_CRYPTO[{2'h3 - o[1:0], 3'h0} +: 8];
    end else if (o == scif_pkg::OFS_STD) begin
      dsc.data = dsc.std_sel ? scif_pkg::STD_140_3 :
                 scif_pkg::STD_140_2;
    end else if (o == scif_pkg::OFS_LEVEL) begin
      dsc.data = dsc.level;
    end else if (o < scif_pkg::OFS_HW) begin
      dsc.data = 8'h00;
    end else if (o < scif_pkg::OFS_VER) begin
      dsc.data = str_byte(scif_pkg::HW_STR, scif_pkg::HW_STR_LEN,
                          o - scif_pkg::OFS_HW);
    end else if (o < scif_pkg::OFS_NAME) begin
      dsc.data = str_byte(scif_pkg::VER_STR, scif_pkg::VER_STR_LEN,
                          o - scif_pkg::OFS_VER);
    end else begin
      dsc.data = str_byte(scif_pkg::NAME_STR, scif_pkg::NAME_STR_LEN,
                          o - scif_pkg::OFS_NAME);
    end
  end

endmodule

// ==== src/scif_desc_if.sv ====
/*
 * Carrier between the stream sequencer and the descriptor byte source.
 * Assumes both ends sit in the same clock domain; content is combinational.
 */
interface scif_desc_if;
  logic [9:0] offset;
  logic std_sel;
  logic [7:0] level;
  logic [7:0] data;

  modport src (input offset, input std_sel, input level, output data);
  modport user (output offset, output std_sel, output level, input data);
endinterface

// ==== src/scif_pkg.sv ====
/*
 * Constants for the security compliance information formatter: request
 * codes, response layout, descriptor fields, strings and credentials.
 * Assumes a single clock domain and byte-wide streaming toward the host.
 */
// How it works
// - Protocol 00h, specific 0002h returns compliance layout
// - Bytes 0-3 hold m-3, descriptors from 4
// - Pad bytes after descriptors are all zero
// - Descriptor: type, zero, length, then specific data
// - Several same-type descriptors may be sent
// - Only type 0001h is ever emitted
// - Length counts bytes after it; type selects meaning
// - Crypto descriptor: type 0001h, length 0000 0208h
// - Byte 8: 32h or 33h related standard
// - Byte 9 level character; bytes 10-15 zero
// - Bytes 16-143 hardware version, null padded
// - Bytes 144-271 certified version, independent of inquiry
// - Bytes 272-527 module name, null padded
// - Factory credential seeds owner and admin credentials
package scif_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Request decode
  localparam logic [7:0] PROTO_INFO = 8'h00;
  localparam logic [15:0] SPEC_COMPLIANCE = 16'h0002;

  ////////////////////////////////////////////////////////////////////////
  // Response layout
  localparam logic [31:0] HDR_BYTES = 32'h0000_0004;
  localparam logic [31:0] DESC_BYTES = 32'h0000_0210;
  localparam logic [9:0] DESC_LAST_OFS = 10'h20F;
  localparam logic [1:0] MAX_DESC = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Descriptor field offsets and fixed values
  localparam logic [9:0] OFS_TYPE = 10'h000;
  localparam logic [9:0] OFS_LEN = 10'h004;
  localparam logic [9:0] OFS_STD = 10'h008;
  localparam logic [9:0] OFS_LEVEL = 10'h009;
  localparam logic [9:0] OFS_HW = 10'h010;
  localparam logic [9:0] OFS_VER = 10'h090;
  localparam logic [9:0] OFS_NAME = 10'h110;
  localparam logic [15:0] DESC_TYPE_CRYPTO = 16'h0001;
  localparam logic [31:0] DESC_LEN_CRYPTO = 32'h0000_0208;
  localparam logic [7:0] STD_140_2 = 8'h32;
  localparam logic [7:0] STD_140_3 = 8'h33;

  ////////////////////////////////////////////////////////////////////////
  // Identification strings, right aligned, at most 16 characters
  localparam logic [127:0] HW_STR = "HW-REV-A";
  localparam logic [9:0] HW_STR_LEN = 10'h008;
  localparam logic [127:0] VER_STR = "FW-1.00";
  localparam logic [9:0] VER_STR_LEN = 10'h007;
  localparam logic [127:0] NAME_STR = "CRYPTO CORE";
  localparam logic [9:0] NAME_STR_LEN = 10'h00B;

  ////////////////////////////////////////////////////////////////////////
  // Credentials; the factory value is arbitrary
  localparam logic [31:0] FACTORY_CRED = 32'hC0DE_0001;
  localparam logic [1:0] CRED_OWNER = 2'h0;
  localparam logic [1:0] CRED_RANGE = 2'h1;
  localparam logic [1:0] CRED_ERASE = 2'h2;

  typedef enum logic [0:0] {ST_IDLE, ST_SEND} scif_state_type;

endpackage

// ==== src/scif_top.sv ====
/*
 * Security compliance information formatter: takes a security protocol
 * in request, streams the compliance response bytes toward the host and
 * keeps the factory and ownership credentials.
 * Assumes request and stream signals are synchronous to MCLK_I.
 */
module scif_top (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // Request
  input wire logic REQ_VALID_I,
  input wire logic [7:0] REQ_PROTOCOL_I,
  input wire logic [15:0] REQ_SPECIFIC_I,
  input wire logic [31:0] REQ_ALLOC_LEN_I,
  input wire logic [1:0] REQ_DESC_COUNT_I,
  input wire logic REQ_STD_SEL_I,
  input wire logic [7:0] REQ_LEVEL_I,
  output logic REQ_READY_O,
  output logic REQ_REJECT_O,
  output logic REQ_DONE_O,
  // Response stream
  output logic DATA_VALID_O,
  output logic [7:0] DATA_O,
  output logic DATA_LAST_O,
  input wire logic DATA_READY_I,
  // Credentials
  input wire logic CRED_WR_I,
  input wire logic [1:0] CRED_SEL_I,
  input wire logic [31:0] CRED_DATA_I,
  output logic [31:0] FACTORY_CRED_O,
  output logic [31:0] OWNER_CRED_O,
  output logic [31:0] RANGE_ADMIN_CRED_O,
  output logic [31:0] ERASE_ADMIN_CRED_O
);

  scif_pkg::scif_state_type state_reg, state_next;
  logic [31:0] pos_reg, pos_next;
  logic [31:0] alloc_reg, alloc_next;
  logic [1:0] count_reg, count_next;
  logic [9:0] off_reg, off_next;
  logic std_reg, std_next;
  logic [7:0] level_reg, level_next;
  logic valid_reg, valid_next;
  logic [7:0] data_reg, data_next;
  logic last_reg, last_next;
  logic reject_reg, reject_next;
  logic done_reg, done_next;
  logic [31:0] owner_reg, owner_next;
  logic [31:0] range_reg, range_next;
  logic [31:0] erase_reg, erase_next;
  logic [31:0] desc_total;
  logic [31:0] content_len;
  logic [7:0] cur_byte;
  logic load;
  logic match;

  scif_desc_if dif ();

  //////////////////////////////////////////////////////////////////////////
  // Descriptor byte source
  scif_desc i_scif_desc (
    .dsc (dif.src)
  );

  assign dif.offset = off_reg;
  assign dif.std_sel = std_reg;
  assign dif.level = level_reg;

  //////////////////////////////////////////////////////////////////////////
  // Response sizes and the byte at the current position
  assign match = (REQ_PROTOCOL_I == scif_pkg::PROTO_INFO) &&
                 (REQ_SPECIFIC_I == scif_pkg::SPEC_COMPLIANCE);
  assign desc_total = scif_pkg::DESC_BYTES * {30'h0, count_reg};
  assign content_len = scif_pkg::HDR_BYTES + desc_total;

  always_comb begin
    cur_byte = 8'h00;
    if (pos_reg < scif_pkg::HDR_BYTES) begin
      // Big-endian count of descriptor bytes
      cur_byte = desc_total[{2'h3 - pos_reg[1:0], 3'h0} +: 8];
    end else if (pos_reg < content_len) begin
      cur_byte = dif.data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Handshakes
  assign REQ_READY_O = (state_reg == scif_pkg::ST_IDLE);
  assign load = !valid_reg || DATA_READY_I;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    pos_next = pos_reg;
    alloc_next = alloc_reg;
    count_next = count_reg;
    off_next = off_reg;
    std_next = std_reg;
    level_next = level_reg;
    valid_next = valid_reg;
    data_next = data_reg;
    last_next = last_reg;
    reject_next = 1'b0;
    done_next = 1'b0;
    case (state_reg)
      scif_pkg::ST_IDLE: begin
        valid_next = 1'b0;
        last_next = 1'b0;
        if (REQ_VALID_I) begin
          if (!match) begin
            reject_next = 1'b1;
          end else if (REQ_ALLOC_LEN_I == 32'h0000_0000) begin
            done_next = 1'b1;
          end else begin
            state_next = scif_pkg::ST_SEND;
            pos_next = 32'h0000_0000;
            off_next = 10'h000;
            alloc_next = REQ_ALLOC_LEN_I;
            // Zero count sends one descriptor; 1 to 3 are sent as requested
            count_next = (REQ_DESC_COUNT_I == 2'h0) ? 2'h1 :
                         REQ_DESC_COUNT_I;
            std_next = REQ_STD_SEL_I;
            level_next = REQ_LEVEL_I;
          end
        end
      end
      scif_pkg::ST_SEND: begin
        if (load) begin
          if (pos_reg < alloc_reg) begin
            valid_next = 1'b1;
            data_next = cur_byte;
            last_next = (pos_reg == alloc_reg - 32'h0000_0001);
            pos_next = pos_reg + 32'h0000_0001;
            if ((pos_reg >= scif_pkg::HDR_BYTES) &&
                (pos_reg < content_len)) begin
              // Restart the offset for each following descriptor
              off_next = (off_reg == scif_pkg::DESC_LAST_OFS) ? 10'h000 :
                         off_reg + 10'h001;
            end
          end else begin
            // Allocation reached: no further bytes
            valid_next = 1'b0;
            last_next = 1'b0;
            done_next = 1'b1;
            state_next = scif_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_next = scif_pkg::ST_IDLE;
        valid_next = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= scif_pkg::ST_IDLE;
      pos_reg <= 32'h0000_0000;
      alloc_reg <= 32'h0000_0000;
      count_reg <= 2'h1;
      off_reg <= 10'h000;
      std_reg <= 1'b0;
      level_reg <= 8'h00;
      valid_reg <= 1'b0;
      data_reg <= 8'h00;
      last_reg <= 1'b0;
      reject_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pos_reg <= pos_next;
      alloc_reg <= alloc_next;
      count_reg <= count_next;
      off_reg <= off_next;
      std_reg <= std_next;
      level_reg <= level_next;
      valid_reg <= valid_next;
      data_reg <= data_next;
      last_reg <= last_next;
      reject_reg <= reject_next;
      done_reg <= done_next;
    end
  end

  assign DATA_VALID_O = valid_reg;
  assign DATA_O = data_reg;
  assign DATA_LAST_O = last_reg;
  assign REQ_REJECT_O = reject_reg;
  assign REQ_DONE_O = done_reg;

  //////////////////////////////////////////////////////////////////////////
  // Credentials next values; host replaces them after taking ownership
  always_comb begin
    owner_next = owner_reg;
    range_next = range_reg;
    erase_next = erase_reg;
    if (CRED_WR_I) begin
      case (CRED_SEL_I)
        scif_pkg::CRED_OWNER: owner_next = CRED_DATA_I;
        scif_pkg::CRED_RANGE: range_next = CRED_DATA_I;
        scif_pkg::CRED_ERASE: erase_next = CRED_DATA_I;
        default: owner_next = owner_reg;
      endcase
    end
  end

  // Credential registers start from the factory value
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      owner_reg <= scif_pkg::FACTORY_CRED;
      range_reg <= scif_pkg::FACTORY_CRED;
      erase_reg <= scif_pkg::FACTORY_CRED;
    end else begin
      owner_reg <= owner_next;
      range_reg <= range_next;
      erase_reg <= erase_next;
    end
  end

  assign FACTORY_CRED_O = scif_pkg::FACTORY_CRED;
  assign OWNER_CRED_O = owner_reg;
  assign RANGE_ADMIN_CRED_O = range_reg;
  assign ERASE_ADMIN_CRED_O = erase_reg;

endmodule
